// >>> hw/ccptb_top.sv
// holds: two capture/compare/pwm channels and the 8-bit period timer
// assumes: wide timer lives outside; pins arrive asynchronous to the clock
`default_nettype none
module ccptb_top
    import ccptb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [15:0] i_wide_timer,
    input wire logic i_adc_enabled,
    input wire logic [1:0] i_channel_pin,
    output logic [1:0] o_channel_out,
    output logic o_wide_timer_reset,
    output logic o_adc_start,
    output logic o_period_match,
    output logic o_irq_request
);
    // ****************************************
    // register file
    // ****************************************
    logic [7:0] period_timer_count;
    logic [6:0] period_timer_control;
    logic [7:0] period_limit;
    logic [7:0] peripheral_flags_one;
    logic [7:0] peripheral_enables_one;
    logic peripheral_flags_two;
    logic peripheral_enables_two;
    logic [5:0] ch_mode [2];
    logic [7:0] ch_low [2];
    logic [7:0] ch_high [2];
    logic [1:0] ch_event;
    logic [1:0] ch_cap;
    logic pt_tick;
    logic pt_match;
    logic post_done;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [3:0] pre_last;
    logic [9:0] pwm_base;
    logic wr_count;
    logic wr_control;

    assign wr_count = i_wr && (i_addr == ADDR_PT_COUNT);
    assign wr_control = i_wr && (i_addr == ADDR_PT_CONTROL);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            period_timer_control <= RESET_ZERO[6:0];
            period_limit <= RESET_PERIOD_LIMIT;
            peripheral_enables_one <= RESET_ZERO;
            peripheral_enables_two <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_PT_CONTROL: period_timer_control <= i_wdata[6:0]
                    & PT_CONTROL_MASK;
                ADDR_PERIOD_LIMIT: period_limit <= i_wdata;
                ADDR_ENABLES_ONE: peripheral_enables_one <= i_wdata;
                ADDR_ENABLES_TWO: peripheral_enables_two <= i_wdata[0];
                default: ;
            endcase
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            peripheral_flags_one <= RESET_ZERO;
            peripheral_flags_two <= 1'b0;
        end else begin
            if (i_wr && i_addr == ADDR_FLAGS_ONE) begin
                peripheral_flags_one <= i_wdata;
            end
            if (i_wr && i_addr == ADDR_FLAGS_TWO) begin
                peripheral_flags_two <= i_wdata[0];
            end
            if (pt_match && post_done) begin
                peripheral_flags_one[PT_FLAG_BIT] <= 1'b1;
            end
            if (ch_event[0]) begin
                peripheral_flags_one[CH1_FLAG_BIT] <= 1'b1;
            end
            if (ch_event[1]) begin
                peripheral_flags_two <= 1'b1;
            end
        end
    end

    assign o_irq_request = |(peripheral_flags_one & peripheral_enables_one)
        | (peripheral_flags_two & peripheral_enables_two);

    // ****************************************
    // period timer
    // ****************************************
    always_comb begin
        case (period_timer_control[1:0])
            2'b00: pre_last = 4'h0;
            2'b01: pre_last = PRESCALE_4_LAST;
            default: pre_last = PRESCALE_16_LAST;
        endcase
    end

    assign pt_tick = period_timer_control[PT_ON_BIT] && (pre_cnt == pre_last);
    assign pt_match = pt_tick && (period_timer_count == period_limit);
    assign post_done = (post_cnt == period_timer_control[6:POSTSCALE_LSB]);
    assign o_period_match = pt_match;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt <= 4'h0;
        end else if (wr_count || wr_control) begin
            pre_cnt <= 4'h0;
        end else if (period_timer_control[PT_ON_BIT]) begin
            pre_cnt <= pt_tick ? 4'h0 : pre_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            post_cnt <= 4'h0;
        end else if (wr_count || wr_control) begin
            post_cnt <= 4'h0;
        end else if (pt_match) begin
            post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
        end
    end

    // control writes do not touch the count
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            period_timer_count <= RESET_ZERO;
        end else if (wr_count) begin
            period_timer_count <= i_wdata;
        end else if (pt_match) begin
            period_timer_count <= RESET_ZERO;
        end else if (pt_tick) begin
            period_timer_count <= period_timer_count + 8'h01;
        end
    end

    // 10-bit pwm base: count plus prescaler bits; shared by both
    assign pwm_base = {period_timer_count, pre_cnt[3:2]};

    // ****************************************
    // channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ch
            logic pin_meta;
            logic pin_sync;
            logic pin_prev;
            logic rise;
            logic fall;
            logic [3:0] edge_cnt;
            logic [3:0] mode;
            logic [9:0] duty_shadow;
            logic out;
            logic cmp_hit;
            ccptb_kind_type kind;

            assign mode = ch_mode[g][3:0];
            always_comb begin
                case (mode[3:2])
                    2'b00: kind = CCPTB_IDLE;
                    2'b01: kind = CCPTB_CAPTURE;
                    2'b10: kind = CCPTB_COMPARE;
                    2'b11: kind = CCPTB_PWM;
                    default: kind = CCPTB_IDLE;
                endcase
            end

            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    pin_meta <= 1'b0;
                    pin_sync <= 1'b0;
                    pin_prev <= 1'b0;
                end else begin
                    pin_meta <= i_channel_pin[g];
                    pin_sync <= pin_meta;
                    pin_prev <= pin_sync;
                end
            end
            assign rise = pin_sync && !pin_prev;
            assign fall = !pin_sync && pin_prev;

            // prescale change inside capture keeps the count
            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    edge_cnt <= 4'h0;
                end else if (kind != CCPTB_CAPTURE) begin
                    edge_cnt <= 4'h0;
                end else if (rise) begin
                    edge_cnt <= edge_cnt + 4'h1;
                end
            end

            always_comb begin
                ch_cap[g] = 1'b0;
                case (mode)
                    MODE_CAP_FALL: ch_cap[g] = fall;
                    MODE_CAP_RISE: ch_cap[g] = rise;
                    MODE_CAP_RISE4: ch_cap[g] = rise
                        && (edge_cnt[1:0] == PRESCALE_4_LAST[1:0]);
                    MODE_CAP_RISE16: ch_cap[g] = rise
                        && (edge_cnt == PRESCALE_16_LAST);
                    default: ch_cap[g] = 1'b0;
                endcase
            end

            assign cmp_hit = (kind == CCPTB_COMPARE)
                && (i_wide_timer == {ch_high[g], ch_low[g]});
            // match on every cycle the values agree; flag is sticky anyway
            assign ch_event[g] = ch_cap[g] || cmp_hit;

            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    out <= 1'b0;
                    duty_shadow <= 10'h000;
                end else if (kind == CCPTB_IDLE) begin
                    out <= 1'b0;
                end else if (kind == CCPTB_COMPARE) begin
                    if (cmp_hit && mode == MODE_CMP_SET) begin
                        out <= 1'b1;
                    end else if (cmp_hit && mode == MODE_CMP_CLEAR) begin
                        out <= 1'b0;
                    end
                end else if (kind == CCPTB_PWM) begin
                    if (pt_match) begin
                        duty_shadow <= {ch_low[g], ch_mode[g][5:4]};
                        out <= ({ch_low[g], ch_mode[g][5:4]} != 10'h000);
                    end else if (pwm_base == duty_shadow) begin
                        out <= 1'b0;
                    end
                end
            end
            assign o_channel_out[g] = out;
        end
    endgenerate

    // ****************************************
    // value and mode registers
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < 2; k++) begin
                ch_mode[k] <= RESET_ZERO[5:0];
                ch_low[k] <= RESET_ZERO;
                ch_high[k] <= RESET_ZERO;
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (i_wr && i_addr == (k == 0 ? ADDR_CH1_MODE
                        : ADDR_CH2_MODE)) begin
                    ch_mode[k] <= i_wdata[5:0] & MODE_MASK;
                end
                if (i_wr && i_addr == (k == 0 ? ADDR_CH1_LOW
                        : ADDR_CH2_LOW)) begin
                    ch_low[k] <= i_wdata;
                end
                if (i_wr && i_addr == (k == 0 ? ADDR_CH1_HIGH
                        : ADDR_CH2_HIGH) && ch_mode[k][3:2] != 2'b11) begin
                    ch_high[k] <= i_wdata;
                end
                if (ch_cap[k]) begin
                    ch_high[k] <= i_wide_timer[15:8];
                    ch_low[k] <= i_wide_timer[7:0];
                end
                if (ch_mode[k][3:2] == 2'b11 && pt_match) begin
                    ch_high[k] <= ch_low[k];
                end
            end
        end
    end

    // ****************************************
    // special event trigger
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wide_timer_reset <= 1'b0;
            o_adc_start <= 1'b0;
        end else begin
            o_wide_timer_reset <= (gen_ch[0].cmp_hit
                && ch_mode[0][3:0] == MODE_CMP_TRIGGER)
                || (gen_ch[1].cmp_hit
                && ch_mode[1][3:0] == MODE_CMP_TRIGGER);
            o_adc_start <= gen_ch[1].cmp_hit && i_adc_enabled
                && ch_mode[1][3:0] == MODE_CMP_TRIGGER;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= RESET_ZERO;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_FLAGS_ONE: o_rdata <= peripheral_flags_one;
                ADDR_FLAGS_TWO: o_rdata <= {7'h00, peripheral_flags_two};
                ADDR_PT_COUNT: o_rdata <= period_timer_count;
                ADDR_PT_CONTROL: o_rdata <= {1'b0, period_timer_control};
                ADDR_PERIOD_LIMIT: o_rdata <= period_limit;
                ADDR_ENABLES_ONE: o_rdata <= peripheral_enables_one;
                ADDR_ENABLES_TWO: o_rdata <= {7'h00, peripheral_enables_two};
                ADDR_CH1_LOW: o_rdata <= ch_low[0];
                ADDR_CH1_HIGH: o_rdata <= ch_high[0];
                ADDR_CH1_MODE: o_rdata <= {2'b00, ch_mode[0]};
                ADDR_CH2_LOW: o_rdata <= ch_low[1];
                ADDR_CH2_HIGH: o_rdata <= ch_high[1];
                ADDR_CH2_MODE: o_rdata <= {2'b00, ch_mode[1]};
                default: o_rdata <= RESET_ZERO;
            endcase
        end else begin
            o_rdata <= RESET_ZERO;
        end
    end
endmodule // ccptb_top
`default_nettype wire

// >>> pkg/ccptb_pkg.sv
// package: register offsets, field positions, reset values, mode codes
// assumes: 8-bit register port, one instruction clock for the whole block
`default_nettype none
package ccptb_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_FLAGS_ONE = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS_TWO = 8'h0D;
    localparam logic [7:0] ADDR_PT_COUNT = 8'h11;
    localparam logic [7:0] ADDR_PT_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_CH1_LOW = 8'h15;
    localparam logic [7:0] ADDR_CH1_HIGH = 8'h16;
    localparam logic [7:0] ADDR_CH1_MODE = 8'h17;
    localparam logic [7:0] ADDR_CH2_LOW = 8'h1B;
    localparam logic [7:0] ADDR_CH2_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_CH2_MODE = 8'h1D;
    localparam logic [7:0] ADDR_ENABLES_ONE = 8'h8C;
    localparam logic [7:0] ADDR_ENABLES_TWO = 8'h8D;
    localparam logic [7:0] ADDR_PERIOD_LIMIT = 8'h92;
    // ****************************************
    // fields and resets
    // ****************************************
    localparam int POSTSCALE_LSB = 3;
    localparam int PT_ON_BIT = 2;
    localparam int CH1_FLAG_BIT = 2;
    localparam int PT_FLAG_BIT = 1;
    localparam int CH2_FLAG_BIT = 0;
    localparam int DUTY_LSB = 4;
    localparam logic [6:0] PT_CONTROL_MASK = 7'h7F;
    localparam logic [5:0] MODE_MASK = 6'h3F;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_PERIOD_LIMIT = 8'hFF;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
    // ****************************************
    // channel modes
    // ****************************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIGGER = 4'hB;
    typedef enum logic [1:0] {
        CCPTB_IDLE, CCPTB_CAPTURE, CCPTB_COMPARE, CCPTB_PWM
    } ccptb_kind_type;
endpackage : ccptb_pkg
`default_nettype wire

// >>> tb/ccptb_wide_timer_model.sv
// holds: behavioural wide timer standing outside the block
// assumes: same clock as the block, cleared by the block's trigger pulse
`default_nettype none
module ccptb_wide_timer_model
    import ccptb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_hold,
    output logic [15:0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // synchronous count only; async counting would break capture
    // trigger clear wins over counting and holding
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count <= 16'h0000;
        end else if (i_clear) begin
            o_count <= 16'h0000;
        end else if (!i_hold) begin
            o_count <= o_count + 16'h0001;
        end
    end
endmodule // ccptb_wide_timer_model
`default_nettype wire

// >>> tb/ccptb_sva.sv
// holds: port checker for the capture/compare/period timer block
// assumes: bound into ccptb_top, a single clock domain
`default_nettype none
module ccptb_sva
    import ccptb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_adc_enabled,
    input wire logic [1:0] o_channel_out,
    input wire logic o_wide_timer_reset,
    input wire logic o_adc_start,
    input wire logic o_period_match,
    input wire logic o_irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // shadows of written settings
    // ****************************************
    logic [7:0] ctl, en1;
    logic en2;
    logic [3:0] m1, m2;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl <= 8'h00;
            en1 <= 8'h00;
            en2 <= 1'h0;
            m1 <= 4'h0;
            m2 <= 4'h0;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_PT_CONTROL: ctl <= i_wdata;
                ADDR_ENABLES_ONE: en1 <= i_wdata;
                ADDR_ENABLES_TWO: en2 <= i_wdata[0];
                ADDR_CH1_MODE: m1 <= i_wdata[3:0];
                ADDR_CH2_MODE: m2 <= i_wdata[3:0];
                default: ;
            endcase
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    chk_ctl_top_zero: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_PT_CONTROL |-> !o_rdata[7])
        else $error("control bit 7 read as one");
    chk_mode_top_zero: assert property (
        $past(i_rd) && ($past(i_addr) == ADDR_CH1_MODE ||
        $past(i_addr) == ADDR_CH2_MODE) |-> o_rdata[7:6] == 2'h0)
        else $error("mode bits 7-6 read as nonzero");
    chk_timer_off: assert property (
        o_period_match |-> ctl[PT_ON_BIT])
        else $error("period match while timer off");
    chk_match_gap: assert property (
        o_period_match && ctl[1] |=> (!o_period_match || !ctl[1]) [*8])
        else $error("period matches too close for prescale 16");
    chk_trig_mode: assert property (
        o_wide_timer_reset |-> $past(m1) == MODE_CMP_TRIGGER ||
        $past(m2) == MODE_CMP_TRIGGER)
        else $error("wide timer reset outside trigger mode");
    chk_adc_cause: assert property (
        o_adc_start |-> $past(m2) == MODE_CMP_TRIGGER &&
        $past(i_adc_enabled) && o_wide_timer_reset)
        else $error("conversion start without its cause");
    chk_off_low: assert property (
        m1 == MODE_OFF && $past(m1) == MODE_OFF |-> !o_channel_out[0])
        else $error("channel output high while disabled");
    chk_irq_masked: assert property (
        en1 == 8'h00 && !en2 |-> !o_irq_request)
        else $error("interrupt request with all enables clear");
endmodule // ccptb_sva
bind ccptb_top ccptb_sva u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_adc_enabled(i_adc_enabled),
    .o_channel_out(o_channel_out), .o_wide_timer_reset(o_wide_timer_reset),
    .o_adc_start(o_adc_start), .o_period_match(o_period_match),
    .o_irq_request(o_irq_request));
`default_nettype wire

// >>> tb/tb_capture_compare_pwm_timebase.sv
// holds: self-checking bench for the capture/compare/period timer block
// assumes: wide timer model beside the block, capture pin driven here
`default_nettype none
module tb_capture_compare_pwm_timebase
    import ccptb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, wr, rd, hold, adc_en, trig, adc_go, pmatch, irq, trig_q;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] pin, chan_out;
    logic [15:0] wt, exp_v;
    int n_fail = 0;
    int samples_checked = 0;
    int n_trig = 0;
    int n_adc = 0;
    int i, n;
    logic [7:0] pre [4] = '{8'h01, 8'h04, 8'h10, 8'h10};
    logic [3:0] post [3] = '{4'h0, 4'h1, 4'hF};
    logic [3:0] cmp [5] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLEAR,
        MODE_CMP_SET, MODE_CMP_TRIGGER};
    logic cmp_out [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
    logic [3:0] cap [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4,
        MODE_CAP_RISE16};
    int edges [4] = '{1, 1, 4, 16};
    ccptb_top dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_wide_timer(wt), .i_adc_enabled(adc_en), .i_channel_pin(pin),
        .o_channel_out(chan_out), .o_wide_timer_reset(trig),
        .o_adc_start(adc_go), .o_period_match(pmatch), .o_irq_request(irq));
    ccptb_wide_timer_model far (.i_core_clk(clk), .i_nrst(nrst),
        .i_clear(trig), .i_hold(hold), .o_count(wt));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // count trigger rises: one match stands until the cleared timer shows
    always @(posedge clk) begin
        trig_q <= trig;
        n_trig <= n_trig + int'(trig === 1'h1 && trig_q !== 1'h1);
        n_adc <= n_adc + int'(adc_go === 1'h1);
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] seen,
        input logic [7:0] e);
        samples_checked++;
        if (seen !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bail();
        n_fail++;
        $display("CHECK FAILED wait expected done seen timeout");
        summarize();
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(nm, rdata, e);
    endtask
    task automatic gap(output int g);
        int k;
        g = -1;
        for (k = 0; k < 600; k++) begin
            cyc(1);
            if (g >= 0) g++;
            if (pmatch === 1'h1) begin
                if (g > 0) break;
                g = 0;
            end
        end
        if (k == 600) bail();
    endtask
    task automatic count_to_irq(output int c);
        int k;
        c = 0;
        for (k = 0; k < 600; k++) begin
            #1;
            if (irq === 1'h1) break;
            if (pmatch === 1'h1) c++;
            @(posedge clk);
        end
        if (k == 600) bail();
    endtask
    task automatic pulses(input int p);
        repeat (p) begin
            @(posedge clk);
            pin[0] <= 1'h1;
            repeat (4) @(posedge clk);
            pin[0] <= 1'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic step_timer();
        @(posedge clk);
        hold <= 1'h0;
        repeat (7) @(posedge clk);
        hold <= 1'h1;
        cyc(1);
        exp_v = wt;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        nrst = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        hold = 1'h0;
        adc_en = 1'h0;
        addr = 8'h00;
        wdata = 8'h00;
        pin = 2'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        rd_chk("limit", ADDR_PERIOD_LIMIT, RESET_PERIOD_LIMIT);
        rd_chk("control", ADDR_PT_CONTROL, RESET_ZERO);
        rd_chk("flags", ADDR_FLAGS_ONE, RESET_ZERO);
        rd_chk("enables", ADDR_ENABLES_ONE, RESET_ZERO);
        rd_chk("unmapped", 8'h40, 8'h00);
        wr_reg(ADDR_PT_COUNT, 8'h5A);
        wr_reg(ADDR_PT_CONTROL, 8'hFB);
        rd_chk("count kept", ADDR_PT_COUNT, 8'h5A);
        rd_chk("control bits", ADDR_PT_CONTROL, 8'h7B);
        wr_reg(ADDR_CH1_MODE, 8'hFF);
        rd_chk("mode bits", ADDR_CH1_MODE, 8'h3F);
        wr_reg(ADDR_CH1_MODE, 8'h00);
        wr_reg(ADDR_CH1_HIGH, 8'hC3);
        rd_chk("value high", ADDR_CH1_HIGH, 8'hC3);
        $display("test registers done");
        wr_reg(ADDR_PERIOD_LIMIT, 8'h03);
        for (i = 0; i < 4; i++) begin
            wr_reg(ADDR_PT_CONTROL, 8'h04 | 8'(i));
            gap(n);
            chk("period gap", 8'(n), pre[i] << 2);
        end
        $display("test prescale done");
        wr_reg(ADDR_PERIOD_LIMIT, 8'h00);
        wr_reg(ADDR_ENABLES_ONE, 8'h02);
        for (i = 0; i < 3; i++) begin
            wr_reg(ADDR_PT_CONTROL, 8'h00);
            wr_reg(ADDR_FLAGS_ONE, 8'h00);
            wr_reg(ADDR_PT_CONTROL, {1'h0, post[i], 3'h4});
            count_to_irq(n);
            chk("postscale", 8'(n), {4'h0, post[i]} + 8'h01);
        end
        wr_reg(ADDR_PT_CONTROL, 8'h00);
        wr_reg(ADDR_ENABLES_ONE, 8'h00);
        wr_reg(ADDR_FLAGS_ONE, 8'h00);
        $display("test postscale done");
        // a frozen wide timer gives compare a steady target
        @(posedge clk);
        hold <= 1'h1;
        cyc(2);
        n = n_trig;
        for (i = 0; i < 5; i++) begin
            wr_reg(ADDR_CH1_LOW, ~wt[7:0]);
            wr_reg(ADDR_FLAGS_ONE, 8'h00);
            wr_reg(ADDR_CH1_MODE, {4'h0, cmp[i]});
            wr_reg(ADDR_CH1_HIGH, wt[15:8]);
            wr_reg(ADDR_CH1_LOW, wt[7:0]);
            cyc(3);
            chk("compare out", {7'h00, chan_out[0]},
                {7'h00, cmp_out[i]});
            rd_chk("compare flag", ADDR_FLAGS_ONE, 8'h04);
        end
        chk("trigger pulses", 8'(n_trig - n), 8'h01);
        wr_reg(ADDR_CH1_MODE, {4'h0, MODE_OFF});
        cyc(3);
        chk("off out", {7'h00, chan_out[0]}, 8'h00);
        @(posedge clk);
        adc_en <= 1'h1;
        n = n_adc;
        wr_reg(ADDR_CH2_MODE, {4'h0, MODE_CMP_TRIGGER});
        cyc(3);
        chk("adc start", {7'h00, n_adc > n}, 8'h01);
        rd_chk("ch2 flag", ADDR_FLAGS_TWO, 8'h01);
        wr_reg(ADDR_CH2_MODE, {4'h0, MODE_OFF});
        $display("test compare done");
        for (i = 0; i < 4; i++) begin
            wr_reg(ADDR_CH1_MODE, {4'h0, MODE_OFF});
            wr_reg(ADDR_CH1_MODE, {4'h0, cap[i]});
            wr_reg(ADDR_FLAGS_ONE, 8'h00);
            pulses(edges[i] - 1);
            rd_chk("early flag", ADDR_FLAGS_ONE, 8'h00);
            pulses(1);
            step_timer();
            pulses(edges[i]);
            rd_chk("capture low", ADDR_CH1_LOW, exp_v[7:0]);
            rd_chk("capture high", ADDR_CH1_HIGH, exp_v[15:8]);
            rd_chk("capture flag", ADDR_FLAGS_ONE, 8'h04);
        end
        $display("test capture done");
        wr_reg(ADDR_PERIOD_LIMIT, 8'h03);
        wr_reg(ADDR_CH1_LOW, 8'h02);
        wr_reg(ADDR_CH2_LOW, 8'hFF);
        wr_reg(ADDR_CH1_MODE, 8'h0C);
        wr_reg(ADDR_CH2_MODE, 8'h3C);
        wr_reg(ADDR_PT_CONTROL, 8'h04);
        cyc(12);
        wr_reg(ADDR_CH2_HIGH, 8'h55);
        rd_chk("duty latch", ADDR_CH1_HIGH, 8'h02);
        rd_chk("duty locked", ADDR_CH2_HIGH, 8'hFF);
        // duty beyond the period never clears, a mid duty must toggle
        n = 0;
        for (i = 0; i < 8; i++) begin
            cyc(1);
            n += int'(chan_out[0] === 1'h1);
            chk("pwm long duty", {7'h00, chan_out[1]}, 8'h01);
        end
        chk("pwm toggles", 8'(n > 0 && n < 8), 8'h01);
        $display("test pwm done");
        summarize();
    end
endmodule // tb_capture_compare_pwm_timebase
`default_nettype wire
